// File: hw/dpsc_params.svh
`ifndef DPSC_PARAMS_SVH
`define DPSC_PARAMS_SVH

// register offsets (word index on the software port)
`define DPSC_REG_CTRL      4'h0
`define DPSC_REG_ADDR      4'h1
`define DPSC_REG_WDATA     4'h2
`define DPSC_REG_RDATA     4'h3
`define DPSC_REG_STATUS    4'h4
`define DPSC_REG_TIMING    4'h5

// control register fields
`define DPSC_CTRL_GO       0
`define DPSC_CTRL_WRITE    1
`define DPSC_CTRL_FLAG     2
`define DPSC_CTRL_UBE      3
`define DPSC_CTRL_LBE      4
`define DPSC_CTRL_OE       5
`define DPSC_CTRL_MASTER   6
`define DPSC_CTRL_RESET    8'h18

// status register fields
`define DPSC_ST_BUSY       0
`define DPSC_ST_DONE       1
`define DPSC_ST_BLOCKED    2
`define DPSC_ST_FLAG       3

// timing in ns, fastest grade
`define DPSC_CLK_NS        10
`define DPSC_TWP_NS        25
`define DPSC_TWZ_NS        15
`define DPSC_TDW_NS        15
`define DPSC_TWH_NS        12
`define DPSC_TBAA_NS       15
`define DPSC_TWDD_NS       30
`define DPSC_TAPS_NS       5
`define DPSC_TWC_NS        35

// least times round up to whole cycles
`define DPSC_CEIL(ns)      (((ns) + `DPSC_CLK_NS - 1) / `DPSC_CLK_NS)
`define DPSC_TWP_CYC       `DPSC_CEIL(`DPSC_TWP_NS)
`define DPSC_TWZDW_CYC     `DPSC_CEIL(`DPSC_TWZ_NS + `DPSC_TDW_NS)
`define DPSC_TWH_CYC       `DPSC_CEIL(`DPSC_TWH_NS)
`define DPSC_TBAA_CYC      `DPSC_CEIL(`DPSC_TBAA_NS)
`define DPSC_TWDD_CYC      `DPSC_CEIL(`DPSC_TWDD_NS)
`define DPSC_TAPS_CYC      `DPSC_CEIL(`DPSC_TAPS_NS)
`define DPSC_TWC_CYC       `DPSC_CEIL(`DPSC_TWC_NS)

`endif

// File: hw/dpsc_pkg.sv
package dpsc_pkg;

  typedef enum logic [2:0] {
    DPSC_IDLE,
    DPSC_SETUP,
    DPSC_PULSE,
    DPSC_HOLD,
    DPSC_RECOVER
  } dpsc_state_t;

endpackage

// File: hw/dpsc_timer_if.sv
`timescale 1ns/1ps
`default_nettype none

interface dpsc_timer_if #(
  parameter int unsigned CW = 8
);
  logic          load;
  logic [CW-1:0] count;
  logic          expired;

  modport ctrl (output load, output count, input expired);
  modport tmr  (input load, input count, output expired);
endinterface

`default_nettype wire

// File: hw/dpsc_timer.sv
`timescale 1ns/1ps
`default_nettype none

module dpsc_timer #(
  parameter int unsigned CW = 8
) (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  // load and expiry
  dpsc_timer_if.tmr t
);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;

  // expired once the loaded count has run down; it must not look at load, which the
  // sequencer derives from expired, or the two would close a combinational loop
  assign cnt_d     = t.load ? t.count : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign t.expired = (cnt_q == '0);

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

`default_nettype wire

// File: hw/dpsc_host.sv
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dpsc_params.svh"

// Behaviour
// - array access: chip enable low, a byte enable low, flag select high
// - flag access: flag select low with chip enable high or both byte enables high
// - select combination held stable for whole chip-enable-to-end-of-write
// - address changes only while strobe, chip enable or both byte enables high
// - output enable low: pulse is larger of minimum width or turn-off plus setup
// - output enable high: pulse may be just the minimum write width
// - host drives no data while device may still drive the pins
// - flag write then read keeps chip enable high throughout
// - earlier port must lead by arbitration priority setup time; the host does not time this lead, DPSC_TAPS_CYC is unused
// - blocked port holds strobe low write-hold time after busy release
module dpsc_host #(
  parameter int unsigned AW = 13,
  parameter int unsigned DW = 16,
  parameter int unsigned CW = 8
) (
  // clock and reset
  input  wire logic          clk_sys_i,
  input  wire logic          rstn_i,
  // software register port
  input  wire logic [3:0]    reg_addr_i,
  input  wire logic [31:0]   reg_wdata_i,
  input  wire logic          reg_wr_i,
  input  wire logic          reg_rd_i,
  output logic      [31:0]   reg_rdata_o,
  // device port pins
  output logic      [AW-1:0] mem_addr_o,
  output logic               chip_enable_n_o,
  output logic               write_strobe_n_o,
  output logic               output_enable_n_o,
  output logic               upper_byte_enable_n_o,
  output logic               lower_byte_enable_n_o,
  output logic               flag_space_select_n_o,
  output logic               master_select_o,
  input  wire logic [DW-1:0] data_i,
  output logic      [DW-1:0] data_o,
  output logic               data_oe_o,
  input  wire logic          busy_n_i,
  output logic               busy_n_o,
  output logic               busy_oe_o
);

  // flag reads replicate one bit over sixteen lines, so the bus width is fixed;
  // refused at elaboration rather than left to misbehave in silence
  if (DW != 16 || AW < 1 || AW > 16 || CW < 4 || CW > 16) begin : g_bad_params
    $error("dpsc_host: unsupported parameters");
  end

  // least times rounded up to whole clock cycles
  localparam logic [CW-1:0] TWP   = CW'(`DPSC_TWP_CYC);
  localparam logic [CW-1:0] TWZDW = CW'(`DPSC_TWZDW_CYC);
  localparam logic [CW-1:0] TWH   = CW'(`DPSC_TWH_CYC);
  localparam logic [CW-1:0] TWDD  = CW'(`DPSC_TWDD_CYC);
  localparam logic [CW-1:0] TSET  = CW'(`DPSC_TBAA_CYC);
  localparam logic [CW-1:0] TREC  = CW'(`DPSC_TWC_CYC);

  dpsc_pkg::dpsc_state_t state_q;
  dpsc_pkg::dpsc_state_t state_d;

  logic [7:0]    ctrl_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] wdata_q;
  logic [DW-1:0] rdata_q;
  logic          done_q;
  logic          blocked_q;
  logic          flag_q;
  logic [CW-1:0] extra_q;
  logic [31:0]   rd_q;
  // pin copies; all device pins but address, data and master select leave straight from one of these
  logic          ce_n_q;
  logic          we_n_q;
  logic          oe_n_q;
  logic          ub_n_q;
  logic          lb_n_q;
  logic          sem_n_q;
  logic          drv_q;
  logic          busy_n_q;
  logic          busy_oe_q;
  logic          busy_seen_q;

  dpsc_timer_if #(.CW(CW)) tif ();

  dpsc_timer #(.CW(CW)) u_timer (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .t         (tif)
  );

  // decode
  wire sel_ctrl   = (reg_addr_i == `DPSC_REG_CTRL);
  wire sel_addr   = (reg_addr_i == `DPSC_REG_ADDR);
  wire sel_wdata  = (reg_addr_i == `DPSC_REG_WDATA);
  wire sel_rdata  = (reg_addr_i == `DPSC_REG_RDATA);
  wire sel_status = (reg_addr_i == `DPSC_REG_STATUS);
  wire sel_timing = (reg_addr_i == `DPSC_REG_TIMING);
  wire wr_ctrl    = reg_wr_i && sel_ctrl;
  wire wr_addr    = reg_wr_i && sel_addr;
  wire wr_wdata   = reg_wr_i && sel_wdata;
  wire wr_timing  = reg_wr_i && sel_timing;
  wire idle      = (state_q == dpsc_pkg::DPSC_IDLE);
  wire go        = wr_ctrl && reg_wdata_i[`DPSC_CTRL_GO] && idle;
  wire is_write  = ctrl_q[`DPSC_CTRL_WRITE];
  wire is_flag   = ctrl_q[`DPSC_CTRL_FLAG];
  wire is_master = ctrl_q[`DPSC_CTRL_MASTER];
  // slave: busy seen low blocks the write; master: device drives busy to us
  wire busy_in   = !busy_n_i;
  // array access needs a byte enable; flag access keeps both byte enables high
  wire ube_n     = is_flag || !ctrl_q[`DPSC_CTRL_UBE];
  wire lbe_n     = is_flag || !ctrl_q[`DPSC_CTRL_LBE];
  // output enable low needs the longer pulse to let device drivers turn off
  wire [CW-1:0] pulse_len = (!ctrl_q[`DPSC_CTRL_OE]) ?
                            ((TWZDW > TWP) ? TWZDW : TWP) : TWP;
  // extra read wait covers slow far-side paths on top of the data delay
  wire [CW-1:0] read_len  = TWDD + extra_q;
  wire busy_hold = is_write && busy_in;

  wire [31:0] rd_mux =
    sel_ctrl   ? {24'h0, ctrl_q} :
    sel_addr   ? {{(32-AW){1'b0}}, addr_q} :
    sel_wdata  ? {16'h0, wdata_q} :
    sel_rdata  ? {16'h0, rdata_q} :
    sel_status ? {28'h0, flag_q, blocked_q, done_q, !idle} :
    sel_timing ? {{(32-CW){1'b0}}, extra_q} : 32'h0;

  // sequencer: setup with strobe high, pulse stretched while busy, hold, recovery
  always_comb begin
    state_d   = state_q;
    tif.load  = 1'b0;
    tif.count = '0;
    unique case (state_q)
      dpsc_pkg::DPSC_IDLE: begin
        if (go) begin
          state_d   = dpsc_pkg::DPSC_SETUP;
          tif.load  = 1'b1;
          tif.count = TSET;
        end
      end
      dpsc_pkg::DPSC_SETUP: begin
        if (tif.expired) begin
          state_d   = dpsc_pkg::DPSC_PULSE;
          tif.load  = 1'b1;
          tif.count = is_write ? pulse_len : read_len;
        end
      end
      dpsc_pkg::DPSC_PULSE: begin
        if (busy_hold) begin
          // keep strobe low while blocked, then hold for write-hold time
          tif.load  = 1'b1;
          tif.count = TWH;
        end else if (tif.expired) begin
          state_d   = dpsc_pkg::DPSC_HOLD;
          tif.load  = 1'b1;
          tif.count = CW'(1);
        end
      end
      dpsc_pkg::DPSC_HOLD: begin
        if (tif.expired) begin
          state_d   = dpsc_pkg::DPSC_RECOVER;
          tif.load  = 1'b1;
          tif.count = TREC;
        end
      end
      dpsc_pkg::DPSC_RECOVER: begin
        if (tif.expired) begin
          state_d = dpsc_pkg::DPSC_IDLE;
        end
      end
      // three codes of the state vector are unused; fall back to idle
      default: begin
        state_d = dpsc_pkg::DPSC_IDLE;
      end
    endcase
  end

  // one access at a time; a start while busy is dropped, not queued
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      state_q <= dpsc_pkg::DPSC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // software registers; go bit self-clears
  // write data and timing may change any time; an access already under way can pick them up
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ctrl_q  <= `DPSC_CTRL_RESET;
      addr_q  <= '0;
      wdata_q <= '0;
      extra_q <= '0;
    end else begin
      // address and mode only change while idle, so pins stay put in a cycle
      if (wr_ctrl && idle) ctrl_q <= {reg_wdata_i[7:1], 1'b0};
      if (wr_addr && idle) addr_q <= reg_wdata_i[AW-1:0];
      if (wr_wdata) wdata_q <= reg_wdata_i[DW-1:0];
      if (wr_timing) extra_q <= reg_wdata_i[CW-1:0];
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      rd_q <= 32'h0;
    end else begin
      // read data stand for one cycle only, zero otherwise
      rd_q <= reg_rd_i ? rd_mux : 32'h0;
    end
  end

  // status flags; completion sets win over a clear by a new start
  wire finish = (state_q == dpsc_pkg::DPSC_RECOVER) && tif.expired;
  wire sample = (state_q == dpsc_pkg::DPSC_PULSE) && tif.expired && !is_write;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      done_q      <= 1'b0;
      blocked_q   <= 1'b0;
      flag_q      <= 1'b0;
      rdata_q     <= '0;
      busy_seen_q <= 1'b0;
    end else begin
      done_q      <= finish || (done_q && !go);
      busy_seen_q <= (state_q == dpsc_pkg::DPSC_PULSE) && busy_hold;
      // blocked by busy, whether master output or slave input
      blocked_q   <= busy_seen_q || (blocked_q && !go);
      if (sample) begin
        rdata_q <= data_i;
        // all lines carry the flag, so lower bit alone reports it
        if (is_flag) flag_q <= data_i[0];
      end
    end
  end

  // pin registers; chip and flag selects lead the strobe by a setup phase
  wire active    = !idle && (state_q != dpsc_pkg::DPSC_RECOVER);
  wire pulsing   = (state_q == dpsc_pkg::DPSC_PULSE);
  wire strobe_on = pulsing && is_write && (state_d == dpsc_pkg::DPSC_PULSE);
  wire drive_on  = pulsing && is_write && !we_n_q;
  always_ff @(posedge clk_sys_i) begin
    if (!rstn_i) begin
      ce_n_q  <= 1'b1;
      we_n_q  <= 1'b1;
      oe_n_q  <= 1'b1;
      ub_n_q  <= 1'b1;
      lb_n_q  <= 1'b1;
      sem_n_q <= 1'b1;
      drv_q   <= 1'b0;
      busy_n_q  <= 1'b1;
      busy_oe_q <= 1'b0;
    end else begin
      // flag cycles keep chip enable high for the whole sequence
      ce_n_q  <= !(active && !is_flag);
      sem_n_q <= !(active && is_flag);
      ub_n_q  <= active ? ube_n : 1'b1;
      lb_n_q  <= active ? lbe_n : 1'b1;
      // strobe falls last so selects settle first and timing refs it
      we_n_q  <= !strobe_on;
      oe_n_q  <= !(active && !is_write && pulsing);
      // drive data only once strobe is low and device outputs are off
      drv_q   <= drive_on;
      // busy stays released: the device or the cascade owns that line
      busy_n_q  <= 1'b1;
      busy_oe_q <= 1'b0;
    end
  end

  assign reg_rdata_o           = rd_q;
  assign mem_addr_o            = addr_q;
  assign chip_enable_n_o       = ce_n_q;
  assign write_strobe_n_o      = we_n_q;
  assign output_enable_n_o     = oe_n_q;
  assign upper_byte_enable_n_o = ub_n_q;
  assign lower_byte_enable_n_o = lb_n_q;
  assign flag_space_select_n_o = sem_n_q;
  assign master_select_o       = ctrl_q[`DPSC_CTRL_MASTER];
  assign data_o                = wdata_q;
  assign data_oe_o             = drv_q;
  // host never drives busy; it is the device's output or a cascade input
  assign busy_n_o              = busy_n_q;
  assign busy_oe_o             = busy_oe_q;

  wire unused_ok = is_master;

endmodule

`default_nettype wire

// File: verification/dpsc_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_host_chk #(
  parameter int unsigned AW = 13
) (
  // clock and reset
  input wire logic          clk_sys_i,
  input wire logic          rstn_i,
  // device pins
  input wire logic [AW-1:0] mem_addr_o,
  input wire logic          chip_enable_n_o,
  input wire logic          write_strobe_n_o,
  input wire logic          upper_byte_enable_n_o,
  input wire logic          lower_byte_enable_n_o,
  input wire logic          flag_space_select_n_o,
  input wire logic          data_oe_o,
  input wire logic          busy_n_i,
  input wire logic          busy_oe_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);
  AST_ARRAY_SEL: assert property (!chip_enable_n_o && !write_strobe_n_o |->
    flag_space_select_n_o && !(upper_byte_enable_n_o && lower_byte_enable_n_o))
    else $error("array write with bad selects");
  AST_FLAG_SEL: assert property (!flag_space_select_n_o |-> chip_enable_n_o)
    else $error("flag access with chip enable low");
  AST_SEL_HOLD: assert property (!write_strobe_n_o |->
    $stable(chip_enable_n_o) && $stable(flag_space_select_n_o))
    else $error("select moved during write");
  AST_ADDR_HOLD: assert property (!$stable(mem_addr_o) |->
    chip_enable_n_o && flag_space_select_n_o && write_strobe_n_o)
    else $error("address moved while selected");
  AST_PULSE_MIN: assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*3])
    else $error("write pulse too short");
  AST_DATA_LATE: assert property ($rose(data_oe_o) |->
    !$past(write_strobe_n_o) && !write_strobe_n_o)
    else $error("data driven before device turned off");
  AST_BUSY_STALL: assert property (!busy_n_i && !write_strobe_n_o |=> !write_strobe_n_o)
    else $error("write ended while busy");
  AST_BUSY_HOLD: assert property ($rose(busy_n_i) && !write_strobe_n_o |->
    !write_strobe_n_o [*2])
    else $error("write hold after busy too short");
  AST_BUSY_OFF: assert property (!busy_oe_o)
    else $error("host drives busy");
  cover property ($fell(write_strobe_n_o));
  cover property ($rose(busy_n_i) && !write_strobe_n_o);
  cover property (!flag_space_select_n_o && !write_strobe_n_o);
endmodule

bind dpsc_host dpsc_host_chk #(.AW(AW)) i_dpsc_host_chk (
  .clk_sys_i, .rstn_i, .mem_addr_o, .chip_enable_n_o, .write_strobe_n_o,
  .upper_byte_enable_n_o, .lower_byte_enable_n_o, .flag_space_select_n_o,
  .data_oe_o, .busy_n_i, .busy_oe_o
);
`default_nettype wire

// File: verification/dpsc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_dev_model (
  // pins from the host
  input  wire logic [12:0] addr_i,
  input  wire logic        ce_n_i,
  input  wire logic        we_n_i,
  input  wire logic        oe_n_i,
  input  wire logic        ub_n_i,
  input  wire logic        lb_n_i,
  input  wire logic        sem_n_i,
  input  wire logic        master_i,
  input  wire logic [15:0] wd_i,
  input  wire logic        wd_oe_i,
  // far port stand-in
  input  wire logic [12:0] far_addr_i,
  input  wire logic        contend_i,
  // device outputs
  output logic      [15:0] rd_o,
  output logic             busy_n_o
);
  logic [15:0] mem_q [0:8191];
  logic [7:0]  flag_q = 8'hff;
  logic [15:0] wlat;
  logic [15:0] last = 16'h0f0f;
  logic [15:0] val;
  logic        arr_rd;
  logic        flg_rd;
  assign arr_rd = !ce_n_i && sem_n_i && !oe_n_i && we_n_i;
  assign flg_rd = !sem_n_i && ce_n_i && !oe_n_i && we_n_i;
  assign val = arr_rd ? mem_q[addr_i] : {16{flag_q[addr_i[2:0]]}};
  always @* if (arr_rd || flg_rd) last = val;
  // no pull on the bus: a released bus shows the inverse of the last value
  assign rd_o = (arr_rd || flg_rd) ? val : ~last;
  always @* if (wd_oe_i) wlat = wd_i;
  // write closes on the strobe rise, selects still low: overlap only
  always @(posedge we_n_i) begin
    if (!ce_n_i && sem_n_i && !ub_n_i) mem_q[addr_i][15:8] <= wlat[15:8];
    if (!ce_n_i && sem_n_i && !lb_n_i) mem_q[addr_i][7:0] <= wlat[7:0];
    if (!sem_n_i && ce_n_i) flag_q[addr_i[2:0]] <= wlat[0];
  end
  // master compares addresses; slave takes busy from the cascade
  assign busy_n_o = !(contend_i && (!master_i || (!ce_n_i && far_addr_i == addr_i)));
endmodule
`default_nettype wire

// File: verification/dpsc_host_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dpsc_host_tb;
  logic        clk_sys_i = 1'b0, rstn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
  logic [12:0] mem_addr_o, far_addr = 13'h0;
  logic        chip_enable_n_o, write_strobe_n_o, output_enable_n_o, master_select_o;
  logic        upper_byte_enable_n_o, lower_byte_enable_n_o, flag_space_select_n_o;
  logic [15:0] data_o, data_i, dev_d;
  logic        data_oe_o, busy_n_i, contend = 1'b0;
  logic        busy_n_o, busy_oe_o;
  int          miscompares = 0, tests_run = 0, pcnt = 0, plen = 0;
  assign data_i = data_oe_o ? data_o : dev_d;
  always #5 clk_sys_i = ~clk_sys_i;
  dpsc_host i_dpsc_host (
    .clk_sys_i, .rstn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .mem_addr_o, .chip_enable_n_o, .write_strobe_n_o, .output_enable_n_o,
    .upper_byte_enable_n_o, .lower_byte_enable_n_o, .flag_space_select_n_o,
    .master_select_o, .data_i, .data_o, .data_oe_o, .busy_n_i, .busy_n_o, .busy_oe_o
  );
  dpsc_dev_model i_dpsc_dev_model (
    .addr_i(mem_addr_o), .ce_n_i(chip_enable_n_o), .we_n_i(write_strobe_n_o),
    .oe_n_i(output_enable_n_o), .ub_n_i(upper_byte_enable_n_o),
    .lb_n_i(lower_byte_enable_n_o), .sem_n_i(flag_space_select_n_o),
    .master_i(master_select_o), .wd_i(data_o), .wd_oe_i(data_oe_o), .far_addr_i(far_addr),
    .contend_i(contend), .rd_o(dev_d), .busy_n_o(busy_n_i)
  );
  // length of the last write pulse in cycles
  always @(posedge clk_sys_i) begin
    if (write_strobe_n_o === 1'b0) pcnt <= pcnt + 1;
    else if (pcnt != 0) begin
      plen <= pcnt;
      pcnt <= 0;
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys_i);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask
  // polls status until done; a lost access ends the run
  task automatic wait_done(output logic [31:0] s);
    for (int i = 0; i < 80; i++) begin
      rd(4'h4, s);
      if (s[1] === 1'b1) return;
    end
    miscompares++;
    $display("BAD done never set");
    report_and_stop();
  endtask
  task automatic t_reset();
    logic [31:0] s;
    rd(4'h0, s);
    chk("ctrl", s, 32'h18);
    rd(4'hf, s);
    chk("unmapped", s, 32'h0);
    chk("pins", {chip_enable_n_o, write_strobe_n_o, flag_space_select_n_o, data_oe_o}, 4'he);
    chk("busy_pins", {busy_n_o, busy_oe_o}, 2'b10);
  endtask
  task automatic t_write(input logic [12:0] a, input logic [15:0] d, input logic [31:0] c,
                         input logic [15:0] exp);
    logic [31:0] s;
    wr(4'h1, {19'h0, a});
    wr(4'h2, {16'h0, d});
    wr(4'h0, c);
    wait_done(s);
    chk("mem", i_dpsc_dev_model.mem_q[a], exp);
    chk("pulse", plen, 3);
  endtask
  task automatic t_flag();
    logic [31:0] s;
    for (int v = 0; v < 2; v++) begin
      wr(4'h1, 32'h5);
      wr(4'h2, v);
      wr(4'h0, 32'h1f);
      wait_done(s);
      chk("flag", i_dpsc_dev_model.flag_q[5], v);
      wr(4'h0, 32'h1d);
      wait_done(s);
      chk("flag_read", s, 32'h2 | (v << 3));
    end
  endtask
  // far side holds busy for six cycles of the pulse; an address write meanwhile is ignored
  task automatic t_busy(input logic [31:0] c, input logic [12:0] f, input logic blk,
                        input int minlen, input logic [15:0] d);
    logic [31:0] s;
    wr(4'h1, 32'h42);
    wr(4'h2, {16'h0, d});
    far_addr <= f;
    contend <= 1'b1;
    wr(4'h0, c);
    for (int i = 0; i < 20 && write_strobe_n_o !== 1'b0; i++) @(posedge clk_sys_i);
    if (write_strobe_n_o !== 1'b0) begin
      miscompares++;
      $display("BAD write strobe never fell");
      report_and_stop();
    end
    wr(4'h1, 32'h999);
    repeat (3) @(posedge clk_sys_i);
    contend <= 1'b0;
    wait_done(s);
    chk("blocked", s[2], blk);
    chk("stretch", plen >= minlen, 1);
    chk("mem", i_dpsc_dev_model.mem_q[13'h42], {16'h0, d});
    chk("addr", mem_addr_o, 13'h42);
  endtask
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rstn_i <= 1'b1;
    t_reset();
    t_write(13'h0123, 16'ha55a, 32'h5b, 16'ha55a);
    t_write(13'h0123, 16'h1234, 32'h0b, 16'h125a);
    t_write(13'h1fff, 16'hbeef, 32'h3b, 16'hbeef);
    wr(4'h1, 32'h123);
    wr(4'h0, 32'h19);
    begin : rd_back
      logic [31:0] s;
      wait_done(s);
      rd(4'h3, s);
      chk("rdata", s, 32'h125a);
    end
    t_flag();
    t_busy(32'h5b, 13'h42, 1'b1, 7, 16'hc0de);
    t_busy(32'h1b, 13'h0, 1'b1, 7, 16'h1357);
    t_busy(32'h5b, 13'h41, 1'b0, 3, 16'h2468);
    report_and_stop();
  end
endmodule
`default_nettype wire
